// File: port_pkg.sv
// Constants and types for the shared analog/wake-up/general-purpose port.
// Assumes an 8-bit register port with byte offsets as listed here.
package port_pkg;

	// Port width
	localparam int unsigned PORT_WIDTH = 8;

	// Register byte offsets
	localparam logic [7:0] ADDR_OUTPUT_VALUE   = 8'h51;
	localparam logic [7:0] ADDR_INPUT_STATUS   = 8'h53;
	localparam logic [7:0] ADDR_DIRECTION      = 8'h55;
	localparam logic [7:0] ADDR_DRIVE_STRENGTH = 8'h57;
	localparam logic [7:0] ADDR_PULL_ENABLE    = 8'h59;
	localparam logic [7:0] ADDR_PULL_POLARITY  = 8'h5B;
	localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h5D;
	localparam logic [7:0] ADDR_IRQ_FLAGS      = 8'h5F;

	// Reset values
	localparam logic [7:0] RST_OUTPUT_VALUE   = 8'h00;
	localparam logic [7:0] RST_DIRECTION      = 8'h00;
	localparam logic [7:0] RST_DRIVE_STRENGTH = 8'h00;
	localparam logic [7:0] RST_PULL_ENABLE    = 8'h00;
	localparam logic [7:0] RST_PULL_POLARITY  = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE     = 8'h00;
	localparam logic [7:0] RST_IRQ_FLAGS      = 8'h00;
	localparam logic [7:0] RST_READ_DATA      = 8'h00;

	// Value read back for a pin with its input buffer off
	localparam logic [7:0] READ_BUFFER_OFF = 8'hFF;

	// Value read for an unmapped offset
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// Pin owner encoding, one-hot
	typedef enum logic [2:0] {
		OWN_CONVERTER = 3'b001,
		OWN_WAKEUP    = 3'b010,
		OWN_GPIO      = 3'b100
	} pin_owner_t;

endpackage

// File: pin_sync.sv
// Two-flop synchroniser plus edge detector for one port pin.
// Assumes the pin may change at any time relative to CORE_CLK.
`timescale 1ns/1ps
module pin_sync
	import port_pkg::*;
(
	input  wire logic clk,       // System clock
	input  wire logic rst,       // Asynchronous reset, high
	input  wire logic pin,       // Raw pin level
	input  wire logic buf_en,    // Digital input buffer enable
	input  wire logic rise_sel,  // 1 rising edge, 0 falling edge
	output logic      level,     // Synchronised level
	output logic      edge_hit   // Active edge, one-cycle pulse
);

	// All state of this module
	typedef struct packed {
		logic meta;  // First stage, read only by the second
		logic sync;  // Second stage
		logic last;  // Previous synchronised level
	} sync_state_t;

	sync_state_t s_q;  // Registered state
	sync_state_t s_d;  // Next state

	// Next-state logic; the buffer gate lets no level in while off
	always_comb begin
		s_d      = s_q;
		s_d.meta = pin & buf_en;
		s_d.sync = s_q.meta;
		s_d.last = s_q.sync;
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign level = s_q.sync;
	// Edge only with the buffer on, so a buffer turning off cannot fake one
	assign edge_hit = buf_en & (rise_sel ? (s_q.sync & ~s_q.last) : (~s_q.sync & s_q.last));

endmodule

// File: analog_shared_port_with_wakeup.sv
// Eight-pin port shared by the converter, the wake-up unit and plain I/O.
// Assumes a simple strobe register port and pins synchronous-safe via pin_sync.
// Function
// - Converter owns pin, then wake-up, then I/O.
// - Digital input needs buffer enable; outputs unaffected.
// - Reset: analog input, buffer off, registers zero; code only zeroes registers, buffer and ANALOG_SEL follow inputs.
// - Output value reaches pin only when output.
// - Output pins read back stored value.
// - Input pins read 1 or pin level.
// - Input status read-only; 1 or pin level.
// - Direction bit 0 input, 1 output.
// - Reduced drive 1 third strength, outputs only.
// - Pull enable acts only on inputs.
// - Polarity 1 pull-down rising, 0 pull-up falling.
// - Polarity effective only while pin is input.
// - Interrupt enable masks or passes flag.
// - Active edge of chosen polarity sets flag.
// - Write one clears flag, zero keeps.
// - Request raised when flag and enable set.
// - No edge detected with buffer disabled.
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module analog_shared_port_with_wakeup
	import port_pkg::*;
(
	input  wire logic       CORE_CLK,       // System clock, 40 MHz
	input  wire logic       RESET,          // Asynchronous reset, high
	input  wire logic [7:0] ADDR,           // Register byte offset
	input  wire logic [7:0] WDATA,          // Write data
	input  wire logic       WR,             // Write strobe
	input  wire logic       RD,             // Read strobe
	output logic      [7:0] RDATA,          // Read data, cycle after RD
	input  wire logic [7:0] PIN_IN,         // Pin levels
	output logic      [7:0] PIN_OUT,        // Driven pin levels
	output logic      [7:0] PIN_OE,         // Pin output enables
	output logic      [7:0] PIN_WEAK,       // Reduced drive select
	output logic      [7:0] PIN_PULL_EN,    // Pull device on
	output logic      [7:0] PIN_PULL_DOWN,  // Pull is down when 1, up when 0
	input  wire logic [7:0] DIG_BUF_EN,     // Digital input buffer enables
	input  wire logic [7:0] CONV_OWN,       // Converter claims pin
	output logic      [7:0] ANALOG_SEL,     // Pin routed to converter input
	output logic      [7:0] WAKEUP_PIN_IN,  // Wake-up unit pin input levels
	output logic            IRQ             // Combined interrupt request
);

	// All state of the port
	typedef struct packed {
		logic [7:0] out_val;  // Stored output values
		logic [7:0] dir;      // Direction, 1 output
		logic [7:0] drive;    // Reduced drive bits
		logic [7:0] pull_en;  // Pull enables
		logic [7:0] pol;      // Pull and edge polarity
		logic [7:0] irq_en;   // Interrupt enables
		logic [7:0] flags;    // Sticky edge flags
		logic [7:0] rdata;    // Read data register
		logic       irq;      // Registered request
	} port_state_t;

	port_state_t s_q;  // Registered state
	port_state_t s_d;  // Next state

	logic [7:0]  level;      // Synchronised pin levels
	logic [7:0]  edge_hit;   // Active-edge pulses
	logic [7:0]  rise_sel;   // Edge polarity per pin
	logic [7:0]  in_status;  // Input status view
	logic [7:0]  port_view;  // Port value view
	logic [7:0]  clr_mask;   // Flags cleared by this write
	logic [7:0]  is_output;  // Pins driven as outputs by plain I/O
	pin_owner_t  owner [8];  // Owner per pin

	// Per-pin synchroniser, owner decode and pad controls
	genvar i;
	generate
		for (i = 0; i < PORT_WIDTH; i++) begin : g_pin
			assign rise_sel[i] = s_q.pol[i] & ~s_q.dir[i];

			pin_sync u_sync (
				.clk      (CORE_CLK),
				.rst      (RESET),
				.pin      (PIN_IN[i]),
				.buf_en   (DIG_BUF_EN[i]),
				.rise_sel (rise_sel[i]),
				.level    (level[i]),
				.edge_hit (edge_hit[i])
			);

			always_comb begin
				if (CONV_OWN[i]) begin
					owner[i] = OWN_CONVERTER;
				end else if (s_q.irq_en[i] && !s_q.dir[i]) begin
					owner[i] = OWN_WAKEUP;
				end else begin
					owner[i] = OWN_GPIO;
				end
			end

			assign is_output[i] = s_q.dir[i] & (owner[i] == OWN_GPIO);

			// value reaches pin only as output
			assign PIN_OUT[i] = is_output[i] & s_q.out_val[i];
			assign PIN_OE[i]  = is_output[i];

			assign PIN_WEAK[i] = is_output[i] & s_q.drive[i];

			assign PIN_PULL_EN[i] = ~s_q.dir[i] & s_q.pull_en[i] & (owner[i] != OWN_CONVERTER);

			assign PIN_PULL_DOWN[i] = ~s_q.dir[i] & s_q.pol[i];

			assign ANALOG_SEL[i] = (owner[i] == OWN_CONVERTER);

			// status is 1 with buffer off
			assign in_status[i] = DIG_BUF_EN[i] ? level[i] : 1'b1;

			assign port_view[i] = s_q.dir[i] ? s_q.out_val[i] : in_status[i];
		end
	endgenerate

	// Wake-up unit sees the same buffered levels
	assign WAKEUP_PIN_IN = in_status;

	assign clr_mask = (WR && ADDR == ADDR_IRQ_FLAGS) ? WDATA : 8'h00;

	// Next-state logic: register writes, flags, read capture
	always_comb begin
		s_d = s_q;
		// Register writes; input status and unmapped offsets ignore writes
		if (WR) begin
			case (ADDR)
				ADDR_OUTPUT_VALUE:   s_d.out_val = WDATA;
				ADDR_DIRECTION:      s_d.dir     = WDATA;
				ADDR_DRIVE_STRENGTH: s_d.drive   = WDATA;
				ADDR_PULL_ENABLE:    s_d.pull_en = WDATA;
				ADDR_PULL_POLARITY:  s_d.pol     = WDATA;
				ADDR_IRQ_ENABLE:     s_d.irq_en  = WDATA;
				default:             s_d.dir     = s_q.dir;
			endcase
		end
		// edge sets flag, set wins over clear
		s_d.flags = (s_q.flags & ~clr_mask) | edge_hit;
		s_d.irq = |(s_d.flags & s_d.irq_en);
		// Read data stands only in the cycle after the strobe
		if (RD) begin
			case (ADDR)
				ADDR_OUTPUT_VALUE:   s_d.rdata = port_view;
				ADDR_INPUT_STATUS:   s_d.rdata = in_status;
				ADDR_DIRECTION:      s_d.rdata = s_q.dir;
				ADDR_DRIVE_STRENGTH: s_d.rdata = s_q.drive;
				ADDR_PULL_ENABLE:    s_d.rdata = s_q.pull_en;
				ADDR_PULL_POLARITY:  s_d.rdata = s_q.pol;
				ADDR_IRQ_ENABLE:     s_d.rdata = s_q.irq_en;
				ADDR_IRQ_FLAGS:      s_d.rdata = s_q.flags;
				default:             s_d.rdata = READ_UNMAPPED;
			endcase
		end else begin
			s_d.rdata = RST_READ_DATA;
		end
	end

	// State register
	// reset clears everything
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			s_q.out_val <= RST_OUTPUT_VALUE;
			s_q.dir     <= RST_DIRECTION;
			s_q.drive   <= RST_DRIVE_STRENGTH;
			s_q.pull_en <= RST_PULL_ENABLE;
			s_q.pol     <= RST_PULL_POLARITY;
			s_q.irq_en  <= RST_IRQ_ENABLE;
			s_q.flags   <= RST_IRQ_FLAGS;
			s_q.rdata   <= RST_READ_DATA;
			s_q.irq     <= 1'b0;
		end else begin
			s_q <= s_d;
		end
	end

	assign RDATA = s_q.rdata;
	assign IRQ   = s_q.irq;

endmodule

// File: port_properties.sv
// Checker on the shared port's top-level ports.
// Assumes one-cycle strobes, never both at once.
`timescale 1ns/1ps
module port_checker
	import port_pkg::*;
(
	input wire logic       CORE_CLK,
	input wire logic       RESET,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic [7:0] PIN_OUT,
	input wire logic [7:0] PIN_OE,
	input wire logic [7:0] PIN_WEAK,
	input wire logic [7:0] PIN_PULL_EN,
	input wire logic [7:0] PIN_PULL_DOWN,
	input wire logic [7:0] DIG_BUF_EN,
	input wire logic [7:0] CONV_OWN,
	input wire logic [7:0] ANALOG_SEL,
	input wire logic [7:0] WAKEUP_PIN_IN,
	input wire logic       IRQ
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);
	a_conv_first: assert property ((PIN_OE & CONV_OWN) == 8'h00 && ANALOG_SEL == CONV_OWN)
		else $error("converter pin driven");
	a_reset_quiet: assert property ($fell(RESET) |-> PIN_OE == 8'h00 && !IRQ)
		else $error("pins active after reset");
	a_out_drive: assert property (WR && ADDR == ADDR_OUTPUT_VALUE
		|=> ((PIN_OUT ^ $past(WDATA)) & PIN_OE) == 8'h00) else $error("output not driven");
	a_out_readback: assert property (RD && ADDR == ADDR_OUTPUT_VALUE
		|=> ((RDATA ^ PIN_OUT) & PIN_OE) == 8'h00) else $error("output read wrong");
	a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside slot");
	a_wake_gate: assert property ((WAKEUP_PIN_IN | DIG_BUF_EN) == 8'hFF)
		else $error("buffer off not one");
	a_weak_out: assert property ((PIN_WEAK & ~PIN_OE) == 8'h00)
		else $error("weak on input");
	a_pull_input: assert property ((PIN_PULL_EN & PIN_OE) == 8'h00)
		else $error("pull on output");
	a_pol_input: assert property ((PIN_PULL_DOWN & PIN_OE) == 8'h00)
		else $error("polarity on output");
	a_mask_irq: assert property (WR && ADDR == ADDR_IRQ_ENABLE && WDATA == 8'h00
		##1 !(WR && ADDR == ADDR_IRQ_ENABLE) |=> !IRQ) else $error("masked request");
	c_irq: cover property ($rose(IRQ));
	c_flag_clear: cover property (WR && ADDR == ADDR_IRQ_FLAGS);
	c_status_read: cover property (RD && ADDR == ADDR_INPUT_STATUS);
endmodule

bind analog_shared_port_with_wakeup port_checker chk (.CORE_CLK, .RESET, .ADDR, .WDATA,
	.WR, .RD, .RDATA, .PIN_OUT, .PIN_OE, .PIN_WEAK, .PIN_PULL_EN, .PIN_PULL_DOWN,
	.DIG_BUF_EN, .CONV_OWN, .ANALOG_SEL, .WAKEUP_PIN_IN, .IRQ);

// File: pad_model.sv
// Pin pads: port drive, an outside driver and pull devices.
// Assumes the bench enables the outside driver bit by bit.
`timescale 1ns/1ps
module pad_model (
	input  wire logic       clk,        // Bench clock
	input  wire logic [7:0] pin_out,    // Port level
	input  wire logic [7:0] pin_oe,     // Port drives
	input  wire logic [7:0] pull_en,    // Pull on
	input  wire logic [7:0] pull_down,  // Pull down
	input  wire logic [7:0] ext_val,    // Outside level
	input  wire logic [7:0] ext_en,     // Outside drives
	output logic      [7:0] pin_lvl     // Pin level
);
	logic [7:0] wig_q = 8'h55;  // Floating pins wander, never hold
	always @(posedge clk) begin
		wig_q <= ~wig_q;
	end
	assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & pull_en & ~pull_down) | (~pin_oe & ~ext_en & ~pull_en & wig_q);
endmodule

// File: tb.sv
// Bench for the shared port with an integer register model.
// Assumes the pad model on the pins and one 40 MHz clock.
`timescale 1ns/1ps
module tb;
	import port_pkg::*;
	logic       CORE_CLK, RESET, WR, RD, IRQ;
	logic [7:0] ADDR, WDATA, RDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_WEAK, PIN_PULL_EN;
	logic [7:0] PIN_PULL_DOWN, DIG_BUF_EN, CONV_OWN, ANALOG_SEL, WAKEUP_PIN_IN, ext_val, ext_en;
	int         mismatches, total_checks, seed, i, lv, m_out, m_dir, m_drv, m_pe, m_pol;
	analog_shared_port_with_wakeup DUT (.CORE_CLK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA,
		.PIN_IN, .PIN_OUT, .PIN_OE, .PIN_WEAK, .PIN_PULL_EN, .PIN_PULL_DOWN, .DIG_BUF_EN,
		.CONV_OWN, .ANALOG_SEL, .WAKEUP_PIN_IN, .IRQ);
	pad_model pads (.clk(CORE_CLK), .pin_out(PIN_OUT), .pin_oe(PIN_OE), .pull_en(PIN_PULL_EN),
		.pull_down(PIN_PULL_DOWN), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(PIN_IN));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One-cycle strobes, launched after an edge
	task automatic wr(input logic [7:0] a, input int d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d[7:0];
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input int exp);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 chk(RDATA, exp[7:0]);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		CORE_CLK = 1'b0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end
	// Watchdog against a hung sequence
	initial begin
		repeat (5000) @(posedge CORE_CLK);
		mismatches++;
		test_done();
	end
	initial begin
		{RESET, WR, RD, ADDR, WDATA, DIG_BUF_EN, CONV_OWN, ext_val, ext_en} = {3'b100, 40'h0, 8'hFF};
		seed = 32'h1b4f_9130;
		repeat (16) @(posedge CORE_CLK);
		RESET <= 1'b0;
		#1 chk(PIN_OE, 8'h00);
		rc(ADDR_DIRECTION, 0);
		rc(ADDR_PULL_ENABLE, 0);
		rc(ADDR_OUTPUT_VALUE, 255);
		rc(ADDR_INPUT_STATUS, 255);
		rc(8'h52, 0);
		$display("reset test done");
		for (i = 0; i < 6; i++) begin
			{m_out, m_dir, m_drv, m_pe, m_pol} = {$random(seed), $random(seed), $random(seed),
				$random(seed), $random(seed)};
			wr(ADDR_OUTPUT_VALUE, m_out);
			wr(ADDR_DIRECTION, m_dir);
			wr(ADDR_DRIVE_STRENGTH, m_drv);
			wr(ADDR_PULL_ENABLE, m_pe);
			wr(ADDR_PULL_POLARITY, m_pol);
			DIG_BUF_EN <= $random(seed);
			CONV_OWN <= (i > 2) ? $random(seed) : 0;
			ext_val <= $random(seed);
			wr(ADDR_INPUT_STATUS, 255);
			repeat (3) @(posedge CORE_CLK);
			#1 lv = (m_dir & ~CONV_OWN & m_out) | (~(m_dir & ~CONV_OWN) & ext_val);
			chk(PIN_OE, 8'(m_dir & ~CONV_OWN));
			chk(PIN_OUT, 8'(m_dir & m_out & ~CONV_OWN));
			chk(PIN_WEAK, 8'(m_dir & m_drv & ~CONV_OWN));
			chk(PIN_PULL_EN, 8'(~m_dir & m_pe & ~CONV_OWN));
			chk(PIN_PULL_DOWN, 8'(~m_dir & m_pol));
			chk(ANALOG_SEL, CONV_OWN);
			chk(WAKEUP_PIN_IN, 8'(~DIG_BUF_EN | lv));
			rc(ADDR_OUTPUT_VALUE, (m_dir & m_out) | (~m_dir & (~DIG_BUF_EN | lv)));
			rc(ADDR_INPUT_STATUS, ~DIG_BUF_EN | lv);
			rc(ADDR_DIRECTION, m_dir);
			rc(ADDR_DRIVE_STRENGTH, m_drv);
		end
		$display("random test done");
		{CONV_OWN, DIG_BUF_EN, ext_val} <= 24'h00_FFF0;
		wr(ADDR_DIRECTION, 0);
		wr(ADDR_PULL_POLARITY, 15);
		wr(ADDR_IRQ_ENABLE, 255);
		wr(ADDR_IRQ_FLAGS, 255);
		rc(ADDR_IRQ_FLAGS, 0);
		ext_val <= 8'h0F;
		repeat (5) @(posedge CORE_CLK);
		rc(ADDR_IRQ_FLAGS, 255);
		chk({7'h00, IRQ}, 8'h01);
		wr(ADDR_IRQ_FLAGS, 15);
		rc(ADDR_IRQ_FLAGS, 240);
		wr(ADDR_IRQ_ENABLE, 0);
		repeat (2) @(posedge CORE_CLK);
		#1 chk({7'h00, IRQ}, 8'h00);
		wr(ADDR_IRQ_FLAGS, 255);
		ext_val <= 8'hF0;
		repeat (5) @(posedge CORE_CLK);
		rc(ADDR_IRQ_FLAGS, 0);
		ext_en <= 8'h00;
		wr(ADDR_PULL_ENABLE, 255);
		repeat (4) @(posedge CORE_CLK);
		rc(ADDR_INPUT_STATUS, 240);
		DIG_BUF_EN <= 8'h00;
		repeat (4) @(posedge CORE_CLK);
		wr(ADDR_IRQ_FLAGS, 255);
		{ext_en, ext_val} <= 16'hFF0F;
		repeat (5) @(posedge CORE_CLK);
		rc(ADDR_IRQ_FLAGS, 0);
		$display("edge test done");
		test_done();
	end
endmodule
